// [rtl/cms_aux_sel.sv]
`timescale 1ns/1ns
module cms_aux_sel (
  input  wire logic       clk,     // system clock
  input  wire logic       rst,     // synchronous reset
  input  wire logic       ce,      // clock enable
  input  wire logic       src_a,   // bus clock strobe
  input  wire logic       src_b,   // external half-rate strobe
  input  wire logic [1:0] want,    // 0 off, 1 source a, 2 source b
  output logic            aux_out  // selected strobe, low while off
);

  logic [1:0] sel_q;

  // the select only moves while the output is low, so no source
  // switch can cut a strobe short
  always_ff @(posedge clk)
  begin
    if (rst)
      sel_q <= 2'h0;
    else if (ce && !aux_out)
      sel_q <= want;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      aux_out <= 1'b0;
    else if (ce)
    begin
      case (sel_q)
        2'h1:    aux_out <= src_a;
        2'h2:    aux_out <= src_b;
        default: aux_out <= 1'b0;
      endcase
    end
  end

endmodule // cms_aux_sel

// [rtl/cms_pkg.sv]
package cms_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [3:0] ADDR_CTRL1 = 4'h0;
  localparam logic [3:0] ADDR_CTRL2 = 4'h4;
  localparam logic [3:0] ADDR_STAT1 = 4'h8;
  localparam logic [3:0] ADDR_STAT2 = 4'hC;

  // field positions inside the control and status words
  localparam int HGO_BIT    = 7;
  localparam int RANGE_BIT  = 6;
  localparam int REFERENCE_SELECT_BIT   = 5;
  localparam int MODE_LSB   = 3;
  localparam int MFD_LSB    = 4;
  localparam int RFD_LSB    = 0;
  localparam int ST_MODE_LSB = 6;
  localparam int ST_RELOCK  = 4;
  localparam int ST_LOCK    = 3;
  localparam int ST_LOSS    = 2;
  localparam int ST_EXT_OK  = 1;
  localparam int ST_OSC_UP  = 0;
  localparam int ST2_DCO    = 0;

  // reset values
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h00;

  // timing counts
  localparam logic [2:0]  MODE_SETTLE_CYCLES = 3'h4;
  localparam logic [12:0] OSC_STARTUP_TICKS  = 13'h1000;
  localparam logic [8:0]  BUS_DIV            = 9'h002;
  localparam logic [8:0]  EXT_AUX_DIV        = 9'h002;
  localparam logic [8:0]  AUX_MIN_RATIO      = 9'h004;
  localparam logic [8:0]  PRESCALE_LOW_RANGE = 9'h040;

  typedef enum logic [1:0] {
    MODE_SELF_CLOCKED = 2'b00,
    MODE_FLL_ENG_INT  = 2'b01,
    MODE_FLL_BYP_EXT  = 2'b10,
    MODE_FLL_ENG_EXT  = 2'b11
  } cms_mode_t;

  typedef enum logic [2:0] {
    ST_SCM = 3'b000,
    ST_FEI = 3'b001,
    ST_FBE = 3'b010,
    ST_FEE = 3'b011,
    ST_OFF = 3'b100
  } cms_state_t;

  typedef struct packed {
    logic      high_gain_select;
    logic      range;
    logic      reference_select;
    cms_mode_t mode_request;
    logic [1:0] spare;
    logic      rsvd;
  } cms_ctrl1_t;

  typedef struct packed {
    logic       rsvd_hi;
    logic [2:0] multiplier_field;
    logic       rsvd_mid;
    logic [2:0] divider_field;
  } cms_ctrl2_t;

endpackage

// [rtl/cms_tick_div.sv]
`timescale 1ns/1ns
module cms_tick_div (
  input  wire logic       clk,      // system clock
  input  wire logic       rst,      // synchronous reset
  input  wire logic       ce,       // clock enable
  input  wire logic       tick_in,  // source clock edge strobe
  input  wire logic [8:0] divisor,  // ticks per output tick
  output logic            tick_out  // divided edge strobe
);

  logic [8:0] cnt_q;

  // count source edges; a divisor shrunk below the count gives a tick on the next source edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q    <= 9'h000;
      tick_out <= 1'b0;
    end
    else if (ce)
    begin
      tick_out <= 1'b0;
      if (tick_in)
      begin
        if (cnt_q + 9'h001 >= divisor)
        begin
          cnt_q    <= 9'h000;
          tick_out <= 1'b1;
        end
        else
        begin
          cnt_q <= cnt_q + 9'h001;
        end
      end
    end
  end

endmodule // cms_tick_div

// [rtl/cms_top.sv]
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
// Contract
// - software writes a two-bit mode request; a separate field shows the mode
// - once its conditions hold, the actual mode equals the requested mode
// - actual mode updates only several bus cycles after a request write
// - mode codes 00..11; output zero off, ext/R bypassed, dco/R else
// - unmet requests hold fallback modes until reference or dco is ready
// - self-clocked requests are honoured except from bypassed external
// - in self-clocked mode the rc reference never shapes the output
// - engaged external gives dco/2R while locking or relocking, then dco/R
// - a first write with reference select zero locks it zero until reset
// - fixed clock for peripherals equals bus clock in bypassed external
// - engaged external: ext/2 if locked and P*N/R at least 4, else bus
// - fixed clock is off in engaged internal and self-clocked modes
// - high gain bit one picks high gain, zero the low power oscillator
// - high gain only takes effect while reference select is one
// - after reselecting external, oscillator start-up completes first
// - in external modes, loss of reference or dco forces self-clocked or bypassed mode
// - an automatic fallback rewrites both request and actual mode
module cms_top (
  input  wire logic        CLK,            // system clock, 100 MHz
  input  wire logic        RST,            // synchronous reset, high
  input  wire logic        CE,             // clock enable, freezes state
  input  wire logic        WB_CYC_I,       // wishbone cycle
  input  wire logic        WB_STB_I,       // wishbone strobe
  input  wire logic        WB_WE_I,        // wishbone write enable
  input  wire logic [3:0]  WB_ADR_I,       // wishbone byte address
  input  wire logic [3:0]  WB_SEL_I,       // wishbone byte lanes
  input  wire logic [31:0] WB_DAT_I,       // wishbone write data
  output logic      [31:0] WB_DAT_O,       // wishbone read data
  output logic             WB_ACK_O,       // wishbone acknowledge
  input  wire logic        DCO_TICK,       // dco output clock edge
  input  wire logic        EXT_TICK,       // external ref clock edge
  input  wire logic        EXT_REF_VALID,  // external reference valid
  input  wire logic        DCO_STABLE,     // dco stable
  input  wire logic        CLOCK_LOSS,     // clock loss flag level
  input  wire logic        REF_LOST,       // reference loss event
  input  wire logic        DCO_LOST,       // dco loss event
  input  wire logic        FLL_LOCKED,     // fll lock level
  input  wire logic        STOP_REQ,       // generator held off
  output logic             GEN_CLK_OUT,    // generator output clock edge
  output logic             BUS_CLK_OUT,    // bus clock edge
  output logic             AUX_CLK_OUT,    // fixed frequency clock edge
  output logic             OSC_AMP_EN,     // oscillator amplifier enable
  output logic             OSC_HIGH_GAIN,  // high gain oscillator select
  output logic      [1:0]  MODE_ACTUAL     // mode actually in use
);

  cms_pkg::cms_ctrl1_t  ctrl1_q;
  cms_pkg::cms_ctrl2_t  ctrl2_q;
  cms_pkg::cms_state_t  state_q;
  cms_pkg::cms_state_t  state_d;
  cms_pkg::cms_mode_t   fb_mode;
  logic                 fallback_ev;
  logic                 ack_q;
  logic [31:0]          dat_q;
  logic                 first_wr_q;
  logic                 reference_select_lock_q;
  logic [2:0]           settle_q;
  logic [12:0]          start_cnt_q;
  logic                 osc_up_q;
  logic                 relock_q;
  logic [1:0]           mode_q;
  logic                 amp_q;
  logic                 hg_q;
  logic                 req_hit;
  logic                 wr1;
  logic                 wr2;
  logic                 ext_ok;
  logic [7:0]           stat1;
  logic [7:0]           stat2;
  logic                 gen_src;
  logic [8:0]           gen_div;
  logic                 ext_half;
  logic [1:0]           aux_want;
  logic [8:0]           r_val;

  // divide factor R as a power of two of the divider field
  function automatic logic [8:0] div_of(input logic [2:0] f);
    div_of = 9'h001 << f;
  endfunction

  // true when prescale times multiplier over R reaches the minimum
  function automatic logic pn_ok(input logic rng, input logic [2:0] m,
                                 input logic [2:0] f);
    logic [15:0] p;
    logic [15:0] n;
    p = rng ? 16'h0001 : {7'h00, cms_pkg::PRESCALE_LOW_RANGE};
    n = 16'h0004 + {12'h000, m, 1'b0};
    pn_ok = (p * n) >= {7'h00, cms_pkg::AUX_MIN_RATIO} * {7'h00, div_of(f)};
  endfunction

  // bus decode; writes land on the edge at which ack is seen
  assign req_hit = WB_CYC_I & WB_STB_I;
  assign wr1     = req_hit & WB_WE_I & ack_q & WB_SEL_I[0]
                   & (WB_ADR_I == cms_pkg::ADDR_CTRL1);
  assign wr2     = req_hit & WB_WE_I & ack_q & WB_SEL_I[0]
                   & (WB_ADR_I == cms_pkg::ADDR_CTRL2);

  // one wait state, ack drops the cycle after it was given
  always_ff @(posedge CLK)
  begin
    if (RST)
      ack_q <= 1'b0;
    else if (CE)
      ack_q <= req_hit & ~ack_q;
  end

  assign stat1 = {mode_q, 1'b0, relock_q, FLL_LOCKED, CLOCK_LOSS,
                  ext_ok, osc_up_q};
  assign stat2 = {7'h00, DCO_STABLE};

  // read data captured in the first cycle; unmapped offsets read zero
  always_ff @(posedge CLK)
  begin
    if (RST)
      dat_q <= 32'h0000_0000;
    else if (CE && req_hit && !ack_q)
    begin
      case (WB_ADR_I)
        cms_pkg::ADDR_CTRL1: dat_q <= {24'h00_0000, ctrl1_q};
        cms_pkg::ADDR_CTRL2: dat_q <= {24'h00_0000, ctrl2_q};
        cms_pkg::ADDR_STAT1: dat_q <= {24'h00_0000, stat1};
        cms_pkg::ADDR_STAT2: dat_q <= {24'h00_0000, stat2};
        default:             dat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign WB_DAT_O = dat_q;
  assign WB_ACK_O = ack_q;

  // first write decides whether the reference select is frozen low
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      first_wr_q  <= 1'b0;
      reference_select_lock_q <= 1'b0;
    end
    else if (CE && wr1 && !first_wr_q)
    begin
      first_wr_q  <= 1'b1;
      reference_select_lock_q <= ~WB_DAT_I[cms_pkg::REFERENCE_SELECT_BIT];
    end
  end

  // control word one; a fallback overrides a write in the same edge
  always_ff @(posedge CLK)
  begin
    if (RST)
      ctrl1_q <= cms_pkg::CTRL1_RESET;
    else if (CE)
    begin
      if (wr1)
      begin
        ctrl1_q <= WB_DAT_I[7:0];
        ctrl1_q.rsvd <= 1'b0;
        ctrl1_q.reference_select <= WB_DAT_I[cms_pkg::REFERENCE_SELECT_BIT]
                                    & ~reference_select_lock_q;
      end
      if (fallback_ev)
        ctrl1_q.mode_request <= fb_mode;
    end
  end

  // control word two, reserved bits read zero
  always_ff @(posedge CLK)
  begin
    if (RST)
      ctrl2_q <= cms_pkg::CTRL2_RESET;
    else if (CE && wr2)
    begin
      ctrl2_q <= WB_DAT_I[7:0];
      ctrl2_q.rsvd_hi  <= 1'b0;
      ctrl2_q.rsvd_mid <= 1'b0;
    end
  end

  // a request write holds mode evaluation off for a few cycles
  always_ff @(posedge CLK)
  begin
    if (RST)
      settle_q <= 3'h0;
    else if (CE)
    begin
      if (wr1)
        settle_q <= cms_pkg::MODE_SETTLE_CYCLES;
      else if (settle_q != 3'h0)
        settle_q <= settle_q - 3'h1;
    end
  end

  // amplifier runs only while a crystal and an external mode are asked
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      amp_q <= 1'b0;
      hg_q  <= 1'b0;
    end
    else if (CE)
    begin
      amp_q <= ctrl1_q.reference_select & ctrl1_q.mode_request[1];
      hg_q  <= ctrl1_q.high_gain_select
               & ctrl1_q.reference_select;
    end
  end

  assign OSC_AMP_EN    = amp_q;
  assign OSC_HIGH_GAIN = hg_q;

  // start-up delay restarts each time the amplifier is switched on;
  // an external clock with no crystal needs no start-up
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      start_cnt_q <= 13'h0000;
      osc_up_q    <= 1'b0;
    end
    else if (CE)
    begin
      if (!ctrl1_q.reference_select)
      begin
        start_cnt_q <= 13'h0000;
        osc_up_q    <= 1'b1;
      end
      else if (!amp_q)
      begin
        start_cnt_q <= 13'h0000;
        osc_up_q    <= 1'b0;
      end
      else if (EXT_TICK && !osc_up_q)
      begin
        start_cnt_q <= start_cnt_q + 13'h0001;
        osc_up_q    <= (start_cnt_q + 13'h0001
                        >= cms_pkg::OSC_STARTUP_TICKS);
      end
    end
  end

  assign ext_ok = EXT_REF_VALID & osc_up_q;

  // next mode; losses act at once, requests wait for the settle time
  always_comb
  begin
    state_d     = state_q;
    fallback_ev = 1'b0;
    fb_mode     = cms_pkg::MODE_SELF_CLOCKED;
    if (STOP_REQ)
      state_d = cms_pkg::ST_OFF;
    else
    begin
      case (state_q)
        cms_pkg::ST_OFF:
          if (ctrl1_q.mode_request != cms_pkg::MODE_FLL_BYP_EXT)
            state_d = cms_pkg::ST_SCM;
          else if (ext_ok)
            state_d = cms_pkg::ST_FBE;
        cms_pkg::ST_FEE:
          if (REF_LOST)
          begin
            state_d     = cms_pkg::ST_SCM;
            fallback_ev = 1'b1;
            fb_mode     = cms_pkg::MODE_SELF_CLOCKED;
          end
          else if (DCO_LOST)
          begin
            state_d     = cms_pkg::ST_FBE;
            fallback_ev = 1'b1;
            fb_mode     = cms_pkg::MODE_FLL_BYP_EXT;
          end
          else if (settle_q == 3'h0)
            state_d = cms_pkg::cms_state_t'({1'b0, ctrl1_q.mode_request});
        cms_pkg::ST_FBE:
          if (REF_LOST)
          begin
            state_d     = cms_pkg::ST_SCM;
            fallback_ev = 1'b1;
            fb_mode     = cms_pkg::MODE_SELF_CLOCKED;
          end
          else if (settle_q == 3'h0)
          begin
            case (ctrl1_q.mode_request)
              cms_pkg::MODE_FLL_ENG_EXT:
                if (!CLOCK_LOSS && DCO_STABLE)
                  state_d = cms_pkg::ST_FEE;
              cms_pkg::MODE_FLL_ENG_INT:
                if (DCO_STABLE)
                  state_d = cms_pkg::ST_FEI;
              default:
                state_d = cms_pkg::ST_FBE;
            endcase
          end
        default:
          if (settle_q == 3'h0)
          begin
            case (ctrl1_q.mode_request)
              cms_pkg::MODE_FLL_ENG_INT:
                if (DCO_STABLE)
                  state_d = cms_pkg::ST_FEI;
              cms_pkg::MODE_FLL_BYP_EXT:
                if (ext_ok)
                  state_d = cms_pkg::ST_FBE;
              cms_pkg::MODE_FLL_ENG_EXT:
                if (ext_ok && DCO_STABLE)
                  state_d = cms_pkg::ST_FEE;
              default:
                state_d = cms_pkg::ST_SCM;
            endcase
          end
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_q <= cms_pkg::ST_SCM;
      mode_q  <= cms_pkg::MODE_SELF_CLOCKED;
    end
    else if (CE)
    begin
      state_q <= state_d;
      mode_q  <= state_d[1:0];
    end
  end

  assign MODE_ACTUAL = mode_q;

  // halved output while first locking or relocking after a new multiplier;
  // an unexpected unlock later keeps the full rate
  always_ff @(posedge CLK)
  begin
    if (RST)
      relock_q <= 1'b0;
    else if (CE)
    begin
      if ((state_d == cms_pkg::ST_FEE && state_q != cms_pkg::ST_FEE)
          || (wr2 && WB_DAT_I[6:4] != ctrl2_q.multiplier_field))
        relock_q <= 1'b1;
      else if (FLL_LOCKED || state_q != cms_pkg::ST_FEE)
        relock_q <= 1'b0;
    end
  end

  // output source: nothing off, external in bypass, dco otherwise;
  // the rc reference is never a source here
  assign r_val   = div_of(ctrl2_q.divider_field);
  assign gen_src = (state_q == cms_pkg::ST_OFF) ? 1'b0 :
                   (state_q == cms_pkg::ST_FBE) ? EXT_TICK :
                   DCO_TICK;
  assign gen_div = (state_q == cms_pkg::ST_FEE && relock_q) ?
                   {r_val[7:0], 1'b0} : r_val;

  cms_tick_div u_gen_div (
    .clk      (CLK),
    .rst      (RST),
    .ce       (CE),
    .tick_in  (gen_src),
    .divisor  (gen_div),
    .tick_out (GEN_CLK_OUT)
  );

  cms_tick_div u_bus_div (
    .clk      (CLK),
    .rst      (RST),
    .ce       (CE),
    .tick_in  (GEN_CLK_OUT),
    .divisor  (cms_pkg::BUS_DIV),
    .tick_out (BUS_CLK_OUT)
  );

  cms_tick_div u_ext_div (
    .clk      (CLK),
    .rst      (RST),
    .ce       (CE),
    .tick_in  (EXT_TICK),
    .divisor  (cms_pkg::EXT_AUX_DIV),
    .tick_out (ext_half)
  );

  // fixed clock source choice; off in the two internal modes
  always_comb
  begin
    case (state_q)
      cms_pkg::ST_FBE:
        aux_want = 2'h1;
      cms_pkg::ST_FEE:
        aux_want = (FLL_LOCKED && pn_ok(ctrl1_q.range,
                    ctrl2_q.multiplier_field, ctrl2_q.divider_field))
                   ? 2'h2 : 2'h1;
      default:
        aux_want = 2'h0;
    endcase
  end

  cms_aux_sel u_aux_sel (
    .clk     (CLK),
    .rst     (RST),
    .ce      (CE),
    .src_a   (BUS_CLK_OUT),
    .src_b   (ext_half),
    .want    (aux_want),
    .aux_out (AUX_CLK_OUT)
  );

endmodule // cms_top

// [sim/cms_ext_src.sv]
`timescale 1ns/1ns
module cms_ext_src #(
  parameter int PERIOD = 4  // bench clock cycles per reference edge
) (
  input  wire logic clk,    // bench clock
  input  wire logic run,    // source powered and running
  output logic      tick,   // reference edge strobe
  output logic      ok      // reference meets its minimum rate
);
  int cnt_q = 0;

  // a stopped source shows no edges at all, so no stale strobe lingers
  always_ff @(posedge clk)
    cnt_q <= (!run || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
  assign tick = run && cnt_q == PERIOD - 1;
  assign ok   = run;
endmodule // cms_ext_src

// [sim/cms_top_sva.sv]
`timescale 1ns/1ns
module cms_top_chk (
  input wire logic        CLK,            // clock
  input wire logic        RST,            // sync reset
  input wire logic        CE,             // enable
  input wire logic        WB_CYC_I,       // cycle
  input wire logic        WB_STB_I,       // strobe
  input wire logic        WB_WE_I,        // write
  input wire logic [3:0]  WB_ADR_I,       // address
  input wire logic [3:0]  WB_SEL_I,       // lanes
  input wire logic [31:0] WB_DAT_I,       // write data
  input wire logic        WB_ACK_O,       // ack
  input wire logic        EXT_REF_VALID,  // ref ok
  input wire logic        DCO_STABLE,     // dco ok
  input wire logic        CLOCK_LOSS,     // loss flag
  input wire logic        REF_LOST,       // ref loss
  input wire logic        STOP_REQ,       // stop
  input wire logic        GEN_CLK_OUT,    // gen clock
  input wire logic        AUX_CLK_OUT,    // aux clock
  input wire logic        OSC_AMP_EN,     // amp
  input wire logic        OSC_HIGH_GAIN,  // high gain
  input wire logic [1:0]  MODE_ACTUAL     // mode
);
  logic wr1;
  logic calm;
  logic first_q;
  logic lock_q;

  // control write at its ack edge; losses and stop act without settling
  assign wr1 = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_SEL_I[0]
               && WB_ADR_I == cms_pkg::ADDR_CTRL1;
  assign calm = !REF_LOST && !STOP_REQ;

  // only the first write after reset decides the select lock
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      first_q <= 1'b0;
      lock_q  <= 1'b0;
    end
    else if (wr1 && !first_q)
    begin
      first_q <= 1'b1;
      lock_q  <= !WB_DAT_I[cms_pkg::REFERENCE_SELECT_BIT];
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  chk_ack_follows : assert property (
    CE && WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not acked");
  chk_mode_settle : assert property (
    wr1 && calm |=> $stable(MODE_ACTUAL) [*2])
    else $error("mode moved at once after write");
  chk_fbe_keeps : assert property (
    MODE_ACTUAL == 2'h2 && calm |=> MODE_ACTUAL != 2'h0)
    else $error("bypass fell to self-clocked");
  chk_loss_blocks : assert property (
    MODE_ACTUAL == 2'h2 && CLOCK_LOSS && calm |=> MODE_ACTUAL != 2'h3)
    else $error("engaged ext entered with loss flag");
  chk_fei_entry : assert property (
    $changed(MODE_ACTUAL) && MODE_ACTUAL == 2'h1 |-> $past(DCO_STABLE))
    else $error("engaged int without stable dco");
  chk_ext_entry : assert property (
    $changed(MODE_ACTUAL) && MODE_ACTUAL[1] |-> $past(EXT_REF_VALID))
    else $error("external mode without valid ref");
  chk_ref_loss : assert property (
    MODE_ACTUAL[1] && REF_LOST && !STOP_REQ |-> ##[1:2] MODE_ACTUAL == 2'h0)
    else $error("ref loss did not fall back");
  chk_aux_off : assert property (
    !MODE_ACTUAL[1] [*3] |-> !AUX_CLK_OUT)
    else $error("aux clock runs in internal mode");
  chk_ref_lock : assert property (
    lock_q |-> !OSC_AMP_EN && !OSC_HIGH_GAIN)
    else $error("amp enabled after select lock");
  chk_stop_quiet : assert property (
    STOP_REQ [*3] |-> !GEN_CLK_OUT && MODE_ACTUAL == 2'h0)
    else $error("output clock runs while off");

  cov_fee : cover property (MODE_ACTUAL == 2'h3);
  cov_aux_fbe : cover property (MODE_ACTUAL == 2'h2 && AUX_CLK_OUT);
  cov_ref_loss : cover property (MODE_ACTUAL[1] && REF_LOST);
endmodule // cms_top_chk

bind cms_top cms_top_chk i_cms_top_chk (
  .CLK(CLK), .RST(RST), .CE(CE), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O), .EXT_REF_VALID(EXT_REF_VALID),
  .DCO_STABLE(DCO_STABLE), .CLOCK_LOSS(CLOCK_LOSS), .REF_LOST(REF_LOST),
  .STOP_REQ(STOP_REQ), .GEN_CLK_OUT(GEN_CLK_OUT), .AUX_CLK_OUT(AUX_CLK_OUT),
  .OSC_AMP_EN(OSC_AMP_EN), .OSC_HIGH_GAIN(OSC_HIGH_GAIN),
  .MODE_ACTUAL(MODE_ACTUAL));

// [sim/cms_top_tb_top.sv]
`timescale 1ns/1ns
module cms_top_tb_top;
  localparam logic [3:0] A1 = cms_pkg::ADDR_CTRL1;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic        dco_tick = 1'b0;
  logic        ext_run = 1'b0;
  logic        loss = 1'b0;
  logic        ref_lost = 1'b0;
  logic        locked = 1'b0;
  logic        stop = 1'b0;
  logic        dco_ok = 1'b1;
  logic        dco_lost = 1'b0;
  logic        ext_tick, ext_ok, ack, gen, bus, aux, amp, hg;
  logic [1:0]  mode;
  logic [31:0] rdat, q;
  int          bad_count = 0;
  int          compares = 0;
  int          n_gen, n_bus, n_aux, n_ext, n_dco;

  // 100 MHz system clock; the dco edge strobe runs every second cycle
  always #5 clk = ~clk;
  always @(posedge clk) dco_tick <= ~dco_tick;

  cms_ext_src #(.PERIOD(4)) i_cms_ext_src (.clk(clk), .run(ext_run),
    .tick(ext_tick), .ok(ext_ok));
  cms_top i_cms_top (.CLK(clk), .RST(rst), .CE(1'b1), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .DCO_TICK(dco_tick),
    .EXT_TICK(ext_tick), .EXT_REF_VALID(ext_ok), .DCO_STABLE(dco_ok),
    .CLOCK_LOSS(loss), .REF_LOST(ref_lost), .DCO_LOST(dco_lost),
    .FLL_LOCKED(locked), .STOP_REQ(stop), .GEN_CLK_OUT(gen),
    .BUS_CLK_OUT(bus), .AUX_CLK_OUT(aux), .OSC_AMP_EN(amp),
    .OSC_HIGH_GAIN(hg), .MODE_ACTUAL(mode));

  task automatic fail(input string m);
    bad_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, string m);
    compares++;
    if (g !== e) fail($sformatf("%s got %0h want %0h", m, g, e));
  endtask

  // strobe counts drift by an edge or two with phase, hence the margin
  task automatic near(input int g, input int e, input string m);
    compares++;
    if (g < e - 2 || g > e + 2) fail($sformatf("%s %0d vs %0d", m, g, e));
  endtask

  // classic cycle: request held until the edge that samples ack high
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 64);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 64)
    begin
      fail("no ack");
      give_verdict();
    end
  endtask

  // count every strobe once per cycle, after the edge has landed
  task automatic span(input int n);
    {n_gen, n_bus, n_aux, n_ext, n_dco} = 160'h0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      n_gen += gen;
      n_bus += bus;
      n_aux += aux;
      n_ext += ext_tick;
      n_dco += dco_tick;
    end
  endtask

  task automatic wait_mode(input logic [1:0] m, input int lim, string s);
    int n;
    n = 0;
    while (mode !== m && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(mode), 32'(m), s);
  endtask

  function automatic logic [7:0] c1(logic h, logic r, logic [1:0] m);
    return {h, 1'b0, r, m, 3'h0};
  endfunction

  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // a hang ends the run well past the longest start-up wait
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    chk(32'(mode), 32'h0, "mode after reset");
    wb(1'b0, A1, 8'h00);
    chk(q, 32'(cms_pkg::CTRL1_RESET), "ctrl1 reset");
    wb(1'b0, 4'h2, 8'h00);
    chk(q, 32'h0, "unmapped read");
    $display("test reset done");
    wb(1'b1, A1, c1(1'b0, 1'b0, 2'h2));
    span(20);
    chk(32'(mode), 32'h0, "bypass before ref");
    @(posedge clk);
    ext_run <= 1'b1;
    wait_mode(2'h2, 60, "bypass entry");
    chk(32'(amp), 32'h0, "amp locked off");
    span(400);
    near(n_gen, n_ext, "gen from ext");
    near(n_aux, n_bus, "aux is bus");
    $display("test bypass done");
    wb(1'b1, A1, c1(1'b1, 1'b1, 2'h0));
    wb(1'b0, A1, 8'h00);
    chk(32'(q[5]), 32'h0, "select locked");
    span(20);
    chk(32'(mode), 32'h2, "no bypass to self");
    chk(32'(hg), 32'h0, "gain needs select");
    $display("test refusal done");
    @(posedge clk);
    loss <= 1'b1;
    wb(1'b1, A1, c1(1'b0, 1'b0, 2'h3));
    span(30);
    chk(32'(mode), 32'h2, "held by loss flag");
    @(posedge clk);
    loss <= 1'b0;
    wait_mode(2'h3, 60, "engaged ext entry");
    span(400);
    near(n_gen, n_dco / 2, "gen during lock");
    @(posedge clk);
    locked <= 1'b1;
    span(40);
    span(400);
    near(n_gen, n_dco, "gen after lock");
    near(n_aux, n_ext / 2, "aux half ext");
    wb(1'b1, cms_pkg::ADDR_CTRL2, 8'h01);
    wb(1'b1, A1, 8'h58);
    span(40);
    span(400);
    near(n_aux, n_bus, "aux bus, low ratio");
    $display("test engaged done");
    @(posedge clk);
    dco_lost <= 1'b1;
    @(posedge clk);
    dco_lost <= 1'b0;
    wait_mode(2'h2, 4, "dco loss fallback");
    @(posedge clk);
    ref_lost <= 1'b1;
    @(posedge clk);
    ref_lost <= 1'b0;
    wait_mode(2'h0, 4, "ref loss fallback");
    wb(1'b0, A1, 8'h00);
    chk(32'(q[4:3]), 32'h0, "request rewritten");
    span(50);
    chk(n_aux, 32'h0, "aux off self");
    @(posedge clk);
    dco_ok <= 1'b0;
    wb(1'b1, A1, c1(1'b0, 1'b0, 2'h1));
    span(20);
    chk(32'(mode), 32'h0, "int waits for dco");
    @(posedge clk);
    dco_ok <= 1'b1;
    wait_mode(2'h1, 60, "engaged int entry");
    span(50);
    chk(n_aux, 32'h0, "aux off int");
    @(posedge clk);
    stop <= 1'b1;
    span(5);
    span(20);
    chk(n_gen, 32'h0, "off gives no clock");
    @(posedge clk);
    stop <= 1'b0;
    $display("test fallback done");
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wb(1'b1, A1, c1(1'b1, 1'b1, 2'h2));
    span(4);
    chk(32'(hg), 32'h1, "high gain on");
    chk(32'(amp), 32'h1, "amp on");
    span(200);
    chk(32'(mode), 32'h0, "waits start-up");
    wait_mode(2'h2, 20000, "bypass after start-up");
    wb(1'b1, A1, c1(1'b1, 1'b1, 2'h1));
    wait_mode(2'h1, 60, "to engaged int");
    wb(1'b1, A1, c1(1'b0, 1'b1, 2'h2));
    span(4);
    chk(32'(hg), 32'h0, "low power osc");
    $display("test crystal done");
    give_verdict();
  end
endmodule // cms_top_tb_top
